// ---- core/tld_pkg.sv ----
/*
  tld_pkg: shared constants for the t1/e1 line interface digital data side.
  assumes a single 25 MHz system clock; line-rate clocks arrive as sampled inputs.
*/
package tld_pkg;
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned T1_RATE_HZ        = 1544000;
  localparam int unsigned E1_RATE_HZ        = 2048000;
  localparam int unsigned LOS_SPACES        = 175;
  localparam int unsigned LOS_MARKS         = 16;
  localparam int unsigned LOS_WINDOW        = 128;
  localparam int unsigned LOS_MAX_ZEROS     = 100;
  // tx clock deemed absent after this many system cycles without a falling edge
  localparam int unsigned TXCLK_LOSS_CYCLES = 64;
  // qrss: 2^20-1 prbs, taps 20 and 17
  localparam int unsigned QRSS_LEN          = 20;
  localparam logic [19:0] QRSS_SEED         = 20'hfffff;
  typedef enum logic [1:0] {TLD_SRC_NONE, TLD_SRC_TX, TLD_SRC_REF} tld_src_t;
endpackage : tld_pkg

// ---- core/tld_rx_if.sv ----
/*
  tld_rx_if: receive-side handshake between the top and the los monitor.
  assumes one clock domain; bit_stb marks one received bit period.
*/
`timescale 1ns/100ps
`default_nettype none
interface tld_rx_if;
  logic bit_stb;
  logic mark;
  logic loss;
  modport top (output bit_stb, output mark, input loss);
  modport mon (input bit_stb, input mark, output loss);
endinterface : tld_rx_if
`default_nettype wire

// ---- core/tld_los_mon.sv ----
/*
  tld_los_mon: loss-of-signal monitor counting received spaces and marks.
  assumes bit_stb is a one-cycle strobe per received bit.
*/
`timescale 1ns/100ps
`default_nettype none
module tld_los_mon #(
  parameter int unsigned WIN = tld_pkg::LOS_WINDOW
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  tld_rx_if.mon     rx
);
  logic [WIN-1:0] hist_reg;
  logic [7:0]     zrun_reg;
  logic [7:0]     marks_cnt;
  logic           loss_reg;
  logic           zrun_ok_reg;

  always_comb
  begin
    marks_cnt = 8'h00;
    for (int i = 0; i < WIN; i++)
      marks_cnt = marks_cnt + {7'h00, hist_reg[i]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hist_reg    <= '0;
      zrun_reg    <= 8'h00;
      zrun_ok_reg <= 1'b0;
    end
    else if (ce && rx.bit_stb)
    begin
      hist_reg <= {hist_reg[WIN-2:0], rx.mark};
      if (rx.mark)
        zrun_reg <= 8'h00;
      else if (zrun_reg != 8'hff)
        zrun_reg <= zrun_reg + 8'h01;
      // window is clean until a run of 100 zeros appears, reset by a fresh window
      if (!rx.mark && zrun_reg + 8'h01 >= 8'(tld_pkg::LOS_MAX_ZEROS))
        zrun_ok_reg <= 1'b0;
      else if (rx.mark && marks_cnt == 8'h00)
        zrun_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      loss_reg <= 1'b1;
    else if (ce && rx.bit_stb)
    begin
      if (!rx.mark && zrun_reg + 8'h01 >= 8'(tld_pkg::LOS_SPACES))
        loss_reg <= 1'b1;
      else if (loss_reg && marks_cnt >= 8'(tld_pkg::LOS_MARKS) && zrun_ok_reg)
        loss_reg <= 1'b0;
    end
  end

  assign rx.loss = loss_reg;

  property p_los_set;
    @(posedge clk) disable iff (rst)
      (ce && rx.bit_stb && !rx.mark && zrun_reg == 8'(tld_pkg::LOS_SPACES - 1)) |=> loss_reg;
  endproperty
  a_los_set: assert property (p_los_set) else $error("loss not raised after 175 spaces");

  property p_los_hold;
    @(posedge clk) disable iff (rst)
      (loss_reg && marks_cnt < 8'(tld_pkg::LOS_MARKS)) |=> loss_reg;
  endproperty
  a_los_hold: assert property (p_los_hold) else $error("loss cleared with too few marks");
endmodule : tld_los_mon
`default_nettype wire

// ---- core/tld_liu_data.sv ----
/*
  tld_liu_data: digital data side of a t1/e1 line transceiver: error and violation
  insertion on transmit, rail / unipolar / violation outputs and recovered clock on receive.
  assumes all pins are synchronous to clk; line clocks are slow sampled levels.
*/
`timescale 1ns/100ps
`default_nettype none
module tld_liu_data #(
  parameter int unsigned TXCLK_LOSS = tld_pkg::TXCLK_LOSS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic host_mode_sel,
  input  wire logic qrss_mode,
  input  wire logic unipolar_mode,
  input  wire logic remote_loopback,
  input  wire logic rx_edge_select,
  input  wire logic tx_line_clock,
  input  wire logic reference_clock_in,
  input  wire logic tx_data_pos,
  input  wire logic tx_data_neg,
  input  wire logic error_insert_in,
  input  wire logic violation_insert_in,
  input  wire logic line_clock_in,
  input  wire logic line_pos_in,
  input  wire logic line_neg_in,
  output logic      tx_line_pos,
  output logic      tx_line_neg,
  output logic      rx_positive_rail,
  output logic      rx_negative_rail,
  output logic      rx_unipolar_data,
  output logic      rx_violation_flag,
  output logic      rx_recovered_clock,
  output logic      signal_loss_flag,
  output logic      tx_clock_absent
);
  tld_rx_if rxi ();

  logic        txc_d_reg;
  logic        refc_d_reg;
  logic        lnc_d_reg;
  logic [7:0]  txc_idle_reg;
  logic        tx_fall;
  logic        ref_fall;
  logic        samp;
  logic        err_d_reg;
  logic        bpv_d_reg;
  logic        err_pend_reg;
  logic        bpv_pend_reg;
  logic [19:0] prbs_reg;
  logic        last_pol_reg;
  logic        tx_bit;
  logic        ln_rise;
  logic        ln_fall;
  logic        rx_stb;
  logic        rx_mark;
  logic        rx_bpv;
  logic        rx_last_pol_reg;
  logic        host_reg;
  logic        out_clk_src;
  logic        clk_sw_reg;
  logic        use_ref_reg;
  logic        pos_s;
  logic        neg_s;
  logic        rx_launch;

  assign tx_fall  = txc_d_reg && !tx_line_clock;
  assign ref_fall = refc_d_reg && !reference_clock_in;
  assign ln_rise  = !lnc_d_reg && line_clock_in;
  assign ln_fall  = lnc_d_reg && !line_clock_in;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txc_d_reg  <= 1'b0;
      refc_d_reg <= 1'b0;
      lnc_d_reg  <= 1'b0;
    end
    else if (ce)
    begin
      txc_d_reg  <= tx_line_clock;
      refc_d_reg <= reference_clock_in;
      lnc_d_reg  <= line_clock_in;
    end
  end

  // missing tx clock: no falling edge for a fixed number of cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txc_idle_reg    <= 8'h00;
      tx_clock_absent <= 1'b1;
    end
    else if (ce)
    begin
      if (tx_fall)
      begin
        txc_idle_reg    <= 8'h00;
        tx_clock_absent <= 1'b0;
      end
      else if (txc_idle_reg == 8'(TXCLK_LOSS - 1))
        tx_clock_absent <= 1'b1;
      else
        txc_idle_reg <= txc_idle_reg + 8'h01;
    end
  end

  assign samp = tx_clock_absent ? ref_fall : tx_fall;

  // insertion requests: rising edge seen at the sampling edge, one pending each
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      err_d_reg    <= 1'b0;
      bpv_d_reg    <= 1'b0;
      err_pend_reg <= 1'b0;
      bpv_pend_reg <= 1'b0;
    end
    else if (ce && samp)
    begin
      err_d_reg    <= error_insert_in;
      bpv_d_reg    <= violation_insert_in;
      err_pend_reg <= qrss_mode && error_insert_in && !err_d_reg;
      // a request meeting a space waits for the next mark, so none is lost in the pattern
      bpv_pend_reg <= (violation_insert_in && !bpv_d_reg) ||
                      (bpv_pend_reg && (qrss_mode || unipolar_mode) && !tx_bit);
    end
  end

  assign tx_bit = qrss_mode ? (prbs_reg[19] ^ err_pend_reg) : (tx_data_pos | tx_data_neg);

  // transmit encoder; the pattern goes wherever the loopback sends this stream
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prbs_reg     <= tld_pkg::QRSS_SEED;
      last_pol_reg <= 1'b0;
      tx_line_pos  <= 1'b0;
      tx_line_neg  <= 1'b0;
    end
    else if (ce && samp)
    begin
      prbs_reg <= {prbs_reg[18:0], prbs_reg[19] ^ prbs_reg[16]};
      if (qrss_mode || unipolar_mode)
      begin
        if (tx_bit)
        begin
          // violation repeats the previous polarity instead of alternating
          tx_line_pos  <= bpv_pend_reg ? last_pol_reg : !last_pol_reg;
          tx_line_neg  <= bpv_pend_reg ? !last_pol_reg : last_pol_reg;
          last_pol_reg <= bpv_pend_reg ? last_pol_reg : !last_pol_reg;
        end
        else
        begin
          tx_line_pos <= 1'b0;
          tx_line_neg <= 1'b0;
        end
      end
      else
      begin
        tx_line_pos <= tx_data_pos;
        tx_line_neg <= tx_data_neg;
      end
    end
  end

  // receive: remote loopback returns the transmit stream, carrying any inserted error
  assign pos_s   = remote_loopback ? tx_line_pos : line_pos_in;
  assign neg_s   = remote_loopback ? tx_line_neg : line_neg_in;
  assign rx_stb  = ln_rise;
  assign rx_mark = pos_s | neg_s;
  assign rx_bpv  = rx_mark && (pos_s == rx_last_pol_reg) && !(pos_s && neg_s);
  assign rx_launch = (host_reg && rx_edge_select) ? ln_rise : ln_fall;

  assign rxi.bit_stb = ce && rx_stb;
  assign rxi.mark    = rx_mark;

  tld_los_mon #(
    .WIN (tld_pkg::LOS_WINDOW)
  ) u_los (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .rx  (rxi)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      host_reg <= 1'b0;
    else if (ce)
      host_reg <= host_mode_sel;
  end

  // data launched on the falling edge, opposite the valid edge, so it is settled there; host mode with rx_edge_select launches on the rising edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_positive_rail  <= 1'b0;
      rx_negative_rail  <= 1'b0;
      rx_unipolar_data  <= 1'b0;
      rx_violation_flag <= 1'b0;
      rx_last_pol_reg   <= 1'b0;
      signal_loss_flag  <= 1'b1;
    end
    else if (ce)
    begin
      signal_loss_flag <= rxi.loss;
      if (rx_launch)
      begin
        rx_positive_rail <= unipolar_mode ? rx_mark : pos_s;
        rx_negative_rail <= unipolar_mode ? rx_bpv : neg_s;
        rx_unipolar_data <= rx_mark;
        rx_violation_flag <= unipolar_mode && rx_bpv;
        if (rx_mark && !rx_bpv)
          rx_last_pol_reg <= pos_s;
      end
    end
  end

  // clock switch only at a low phase of both sources: no runt pulse
  assign out_clk_src = use_ref_reg ? reference_clock_in : line_clock_in;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      use_ref_reg        <= 1'b1;
      clk_sw_reg         <= 1'b1;
      rx_recovered_clock <= 1'b0;
    end
    else if (ce)
    begin
      clk_sw_reg <= rxi.loss;
      if (clk_sw_reg != use_ref_reg && !rx_recovered_clock && !reference_clock_in && !line_clock_in)
        use_ref_reg <= clk_sw_reg;
      rx_recovered_clock <= (clk_sw_reg != use_ref_reg) ? (rx_recovered_clock & out_clk_src) : out_clk_src;
    end
  end

  property p_err_one;
    @(posedge clk) disable iff (rst)
      (ce && samp && qrss_mode && error_insert_in && err_d_reg) |=> !err_pend_reg;
  endproperty
  a_err_one: assert property (p_err_one) else $error("held error request inserted twice");

  property p_bpv_one;
    @(posedge clk) disable iff (rst)
      (ce && samp && violation_insert_in && bpv_d_reg) |=> (!bpv_pend_reg || $past(bpv_pend_reg));
  endproperty
  a_bpv_one: assert property (p_bpv_one) else $error("held violation request inserted twice");

  property p_samp_src;
    @(posedge clk) disable iff (rst)
      (tx_clock_absent && ce && !ref_fall) |=> $stable(err_d_reg) && $stable(bpv_d_reg);
  endproperty
  a_samp_src: assert property (p_samp_src) else $error("sampled off reference clock edge");

  property p_txc_abs;
    @(posedge clk) disable iff (rst)
      (ce && tx_fall) |=> !tx_clock_absent;
  endproperty
  a_txc_abs: assert property (p_txc_abs) else $error("tx clock edge not recognised");

  property p_uni_flag;
    @(posedge clk) disable iff (rst)
      (ce && !unipolar_mode && !host_reg && ln_fall) |=> !rx_violation_flag;
  endproperty
  a_uni_flag: assert property (p_uni_flag) else $error("violation flag set in bipolar mode");

  property p_rail_nrz;
    @(posedge clk) disable iff (rst)
      (ce && !host_reg && !ln_fall) |=> $stable(rx_positive_rail) && $stable(rx_negative_rail);
  endproperty
  a_rail_nrz: assert property (p_rail_nrz) else $error("rail changed away from launch edge");

  property p_clk_glitch;
    @(posedge clk) disable iff (rst)
      (ce && clk_sw_reg != use_ref_reg && !rx_recovered_clock) |=> !rx_recovered_clock;
  endproperty
  a_clk_glitch: assert property (p_clk_glitch) else $error("recovered clock pulsed during switch");

  property p_mode_pin;
    @(posedge clk) disable iff (rst)
      ce |=> host_reg == $past(host_mode_sel);
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("mode select not followed");

  property p_rail_rise;
    @(posedge clk) disable iff (rst)
      (ce && host_reg && rx_edge_select && !ln_rise) |=> $stable(rx_positive_rail) && $stable(rx_negative_rail);
  endproperty
  a_rail_rise: assert property (p_rail_rise) else $error("rail changed away from rising launch edge");

  property p_rail_pol;
    @(posedge clk) disable iff (rst)
      (ce && rx_launch && !unipolar_mode) |=> rx_positive_rail == $past(pos_s) && rx_negative_rail == $past(neg_s);
  endproperty
  a_rail_pol: assert property (p_rail_pol) else $error("rail does not match received pulse polarity");

  property p_uni_data;
    @(posedge clk) disable iff (rst)
      (ce && rx_launch) |=> rx_unipolar_data == $past(rx_mark);
  endproperty
  a_uni_data: assert property (p_uni_data) else $error("unipolar data does not match received mark");

  property p_flag_set;
    @(posedge clk) disable iff (rst)
      (ce && rx_launch && unipolar_mode && rx_bpv) |=> rx_violation_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("received violation not flagged");

  property p_qrss_bpv;
    @(posedge clk) disable iff (rst)
      (ce && samp && qrss_mode && bpv_pend_reg && tx_bit) |=> tx_line_pos == $past(last_pol_reg);
  endproperty
  a_qrss_bpv: assert property (p_qrss_bpv) else $error("violation not placed in pattern");

  property p_rclk_line;
    @(posedge clk) disable iff (rst)
      (ce && !use_ref_reg && clk_sw_reg == use_ref_reg) |=> rx_recovered_clock == $past(line_clock_in);
  endproperty
  a_rclk_line: assert property (p_rclk_line) else $error("recovered clock not following line clock");

  c_err:  cover property (@(posedge clk) disable iff (rst) err_pend_reg && qrss_mode);
  c_bpv:  cover property (@(posedge clk) disable iff (rst) bpv_pend_reg && samp);
  c_los:  cover property (@(posedge clk) disable iff (rst) $fell(signal_loss_flag));
  c_swch: cover property (@(posedge clk) disable iff (rst) $changed(use_ref_reg));
  c_rise: cover property (@(posedge clk) disable iff (rst) host_reg && rx_edge_select && ln_rise);
endmodule : tld_liu_data
`default_nettype wire

// ---- bench/tld_far_model.sv ----
/*
  tld_far_model: framer and line stand-in: tx clock, reference clock, line pulses, ami tx data.
  assumes clk at 25 MHz; all far-side clocks are slow levels made from it.
*/
`timescale 1ns/100ps
`default_nettype none
module tld_far_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_run,
  input  wire logic [1:0] line_pat,
  output logic            tx_line_clock,
  output logic            reference_clock_in,
  output logic            line_clock_in,
  output logic            line_pos_in,
  output logic            line_neg_in,
  output logic            tx_data_pos,
  output logic            tx_data_neg
);
  logic [3:0] ph_reg;
  logic [4:0] ref_reg;
  logic       pol_reg;
  // stopped clock stands high: no false falling edge
  assign tx_line_clock      = tx_run ? ~ph_reg[3] : 1'b1;
  assign line_clock_in      = ~ph_reg[3];
  assign reference_clock_in = (ref_reg < 5'h0a);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ph_reg      <= 4'h0;
      ref_reg     <= 5'h00;
      pol_reg     <= 1'b0;
      line_pos_in <= 1'b0;
      line_neg_in <= 1'b0;
      tx_data_pos <= 1'b0;
      tx_data_neg <= 1'b0;
    end
    else
    begin
      ph_reg  <= ph_reg + 4'h1;
      ref_reg <= (ref_reg == 5'h13) ? 5'h00 : ref_reg + 5'h01;
      // data moves on the rising edge, stable at the falling one
      if (ph_reg == 4'hf)
      begin
        pol_reg     <= ~pol_reg;
        line_pos_in <= (line_pat == 2'h1) ? pol_reg : (line_pat == 2'h2);
        line_neg_in <= (line_pat == 2'h1) & ~pol_reg;
        tx_data_pos <= pol_reg;
        tx_data_neg <= ~pol_reg;
      end
    end
  end
endmodule : tld_far_model
`default_nettype wire

// ---- bench/tld_liu_data_tb_top.sv ----
/*
  tld_liu_data_tb_top: self-checking bench for the line interface data side.
  assumes tld_far_model drives all line-rate clocks and data.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tld_liu_data_tb_top;
  logic       clk = 1'b0, rst = 1'b1, host = 1'b0, qrss = 1'b0, uni = 1'b0;
  logic       err_in = 1'b0, bpv_in = 1'b0, tx_run = 1'b0;
  logic [1:0] pat = 2'h1;
  logic       txc, refc, lnc, lp, ln, tdp, tdn;
  logic       tlp, tln, rxp, rxn, rdat, rbpv, rclk, los, absent;
  logic       sp, sn, last, have, rprev;
  logic       esel = 1'b0, lb = 1'b0, ptx = 1'b0;
  logic [19:0] hist = 20'h00000;
  int         fails = 0, samples_checked = 0, bpvs = 0, rises = 0, hi = 0, min_hi = 99;
  int         perr = 0, lbe = 0;
  always #20 clk = ~clk;
  tld_far_model u_far (.clk(clk), .rst(rst), .tx_run(tx_run), .line_pat(pat),
    .tx_line_clock(txc), .reference_clock_in(refc), .line_clock_in(lnc),
    .line_pos_in(lp), .line_neg_in(ln), .tx_data_pos(tdp), .tx_data_neg(tdn));
  tld_liu_data #(.TXCLK_LOSS(16)) u_dut (.clk(clk), .rst(rst), .ce(1'b1),
    .host_mode_sel(host), .qrss_mode(qrss), .unipolar_mode(uni), .remote_loopback(lb),
    .rx_edge_select(esel), .tx_line_clock(txc), .reference_clock_in(refc),
    .tx_data_pos(tdp), .tx_data_neg(tdn), .error_insert_in(err_in),
    .violation_insert_in(bpv_in), .line_clock_in(lnc), .line_pos_in(lp),
    .line_neg_in(ln), .tx_line_pos(tlp), .tx_line_neg(tln), .rx_positive_rail(rxp),
    .rx_negative_rail(rxn), .rx_unipolar_data(rdat), .rx_violation_flag(rbpv),
    .rx_recovered_clock(rclk), .signal_loss_flag(los), .tx_clock_absent(absent));
  // line sampled late in the bit, rails compared early in the next bit
  always @(negedge clk)
  begin
    if (u_far.ph_reg == 4'hc)
    begin
      sp = lp;
      sn = ln;
    end
    if (u_far.ph_reg == 4'h4 && (tlp | tln))
    begin
      if (have && last == tlp)
        bpvs++;
      last = tlp;
      have = 1'b1;
    end
    if (u_far.ph_reg == 4'h4)
    begin
      // looped-back data comes out one bit after it was sent
      if (lb && rdat !== ptx)
        lbe++;
      // one flipped pattern bit breaks the recurrence at exactly three bits
      if ((tlp | tln) !== (hist[19] ^ hist[16]))
        perr++;
      hist = {hist[18:0], tlp | tln};
      ptx = tlp | tln;
    end
    if (rclk)
      hi++;
    else if (rprev && hi < min_hi)
      min_hi = hi;
    if (!rclk)
      hi = 0;
    if (rclk && !rprev)
      rises++;
    rprev = rclk;
  end
  task automatic bits(input int n);
    repeat (n) @(negedge clk iff u_far.ph_reg == 4'h4);
  endtask : bits
  task automatic results;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial
  begin
    #2000000;
    fails++;
    results();
  end
  initial
  begin
    have = 1'b0;
    rprev = 1'b0;
    repeat (11) @(posedge clk);
    `CHK("los_rst", 1'b1, los)
    `CHK("absent_rst", 1'b1, absent)
    `CHK("rxp_rst", 1'b0, rxp)
    @(posedge clk) rst <= 1'b0;
    tx_run <= 1'b1;
    bits(40);
    `CHK("absent", 1'b0, absent)
    `CHK("los_marks", 1'b0, los)
    // third pass launches on the rising edge, so the rails show the current bit
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk) host <= (m != 0);
      esel <= (m == 2);
      bits(3);
      repeat (8)
      begin
        bits(1);
        `CHK("rxp", (m == 2) ? lp : sp, rxp)
        `CHK("rxn", (m == 2) ? ln : sn, rxn)
      end
    end
    @(posedge clk) esel <= 1'b0;
    rises = 0;
    bits(25);
    `CHK("rclk_line", 1'b1, rises >= 24 && rises <= 26)
    $display("test rx bipolar done");
    @(posedge clk) pat <= 2'h0;
    bits(150);
    `CHK("los_150", 1'b0, los)
    bits(30);
    `CHK("los_180", 1'b1, los)
    rises = 0;
    bits(25);
    `CHK("rclk_ref", 1'b1, rises >= 19 && rises <= 21)
    @(posedge clk) pat <= 2'h1;
    bits(12);
    `CHK("los_12", 1'b1, los)
    bits(140);
    `CHK("los_rel", 1'b0, los)
    `CHK("rclk_glitch", 1'b1, min_hi >= 8)
    $display("test loss done");
    @(posedge clk) uni <= 1'b1;
    pat <= 2'h2;
    bits(4);
    repeat (4)
    begin
      bits(1);
      `CHK("uni_data", 1'b1, rdat)
      `CHK("uni_bpv", 1'b1, rbpv)
    end
    @(posedge clk) pat <= 2'h1;
    bits(4);
    repeat (4)
    begin
      bits(1);
      `CHK("uni_nobpv", 1'b0, rbpv)
    end
    $display("test unipolar done");
    // insertion lives only in unipolar and pattern modes; unipolar data here is all marks
    bits(4);
    bpvs = 0;
    @(posedge clk) bpv_in <= 1'b1;
    bits(20);
    @(posedge clk) bpv_in <= 1'b0;
    bits(4);
    @(posedge clk) bpv_in <= 1'b1;
    bits(6);
    `CHK("bpv_ext", 2, bpvs)
    @(posedge clk) bpv_in <= 1'b0;
    qrss <= 1'b1;
    bits(8);
    bpvs = 0;
    @(posedge clk) bpv_in <= 1'b1;
    bits(24);
    `CHK("bpv_qrss", 1, bpvs)
    @(posedge clk) lb <= 1'b1;
    bits(2);
    perr = 0;
    lbe = 0;
    @(posedge clk) err_in <= 1'b1;
    bits(30);
    `CHK("err_once", 3, perr)
    `CHK("err_no_bpv", 1, bpvs)
    `CHK("err_loop", 0, lbe)
    $display("test transmit done");
    @(posedge clk) tx_run <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK("absent_stop", 1'b1, absent)
    $display("test tx clock loss done");
    results();
  end
endmodule : tld_liu_data_tb_top
`undef CHK
`default_nettype wire
